/* File: shared/dlr_consts.svh */
// Offsets, subindices, presets and field positions of the drive limit and hardware info block
`ifndef DLR_CONSTS_SVH
`define DLR_CONSTS_SVH
`define DLR_IDX_LIMIT_REACT   16'h3701
`define DLR_IDX_HW_INFO       16'h4012
`define DLR_IDX_HW_CFG        16'h4013
`define DLR_IDX_OP_COND       16'h4014
`define DLR_IDX_BALLAST       16'h4021
`define DLR_SUB_COUNT         8'h00
`define DLR_SUB_1             8'h01
`define DLR_SUB_2             8'h02
`define DLR_SUB_3             8'h03
`define DLR_SUB_4             8'h04
`define DLR_SUB_5             8'h05
`define DLR_CNT_ONE           32'h0000_0001
`define DLR_CNT_BALLAST       32'h0000_0003
`define DLR_CNT_OP_COND       32'h0000_0005
`define DLR_RST_REACT         16'hffff
`define DLR_RST_HW_CFG        32'h0000_0000
`define DLR_RST_BAL_SET       32'h0000_0001
`define DLR_RST_BAL_LIMIT     32'h0000_6860
`define DLR_RST_BAL_HYST      32'h0000_01f4
`define DLR_REACT_NONE        16'hffff
`define DLR_REACT_SLOW_DIS    16'h0001
`define DLR_REACT_QUICK_DIS   16'h0002
`define DLR_REACT_SLOW_QS     16'h0005
`define DLR_REACT_QUICK_QS    16'h0006
`define DLR_STAT_WARN_BIT     7
`define DLR_CMD_QS_BIT        2
`define DLR_BAL_EN_BIT        0
`endif

/* File: shared/dlr_pkg.sv */
// Types shared by the drive limit and hardware info block
package dlr_pkg;
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [15:0] index;
    logic [7:0]  subindex;
    logic [31:0] wdata;
  } dlr_od_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } dlr_od_rsp_t;

  typedef struct packed {
    logic [31:0] supply_mv;
    logic [31:0] logic_mv;
    logic [31:0] board_temp;
  } dlr_sense_t;

  typedef enum logic [2:0] {
    DLR_OP_ENABLED,
    DLR_BRAKE_DIS,
    DLR_BRAKE_QS,
    DLR_SWITCH_ON_DISABLED,
    DLR_QUICK_STOP_ACTIVE
  } dlr_state_t;

  typedef enum logic [1:0] {
    DLR_RAMP_NONE,
    DLR_RAMP_SLOW,
    DLR_RAMP_QUICK
  } dlr_ramp_t;
endpackage : dlr_pkg

/* File: hw/dlr_block.sv */
// Object-dictionary register bank with limit-overrun reaction and ballast control
// Overview of operation
// - On limit overrun set state-word bit 7 warning, then run selected reaction.
// - Reaction code is signed 16-bit read/write, not process-mapped, preset all ones.
// - Reaction code minus one means no reaction, e.g. for homing.
// - Codes 1 and 2 brake slow or quick, then go switch-on-disabled.
// - Codes 5 and 6 brake slow or quick, then quick-stop-active, motor energized.
// - Entering quick-stop-active never clears command-word quick-stop bit 2 itself.
// - Hardware info reports EEPROM size in bytes, read-only, zero means none.
// - Readings: supply mV at 01, logic mV at 02, board temp at 03.
// - Readings are read-only signed 32-bit, entry count reads 5.
// - Hardware configuration word at subindex 01 is read/write, preset zero.
// - Ballast object turns circuit on or off and sets response threshold.
// - Ballast settings bit 0 enables circuit; preset enables it.
// - Threshold at subindex 02 preset 6860 hex, hysteresis at 03 preset 1f4.
`timescale 1ns/1ps
`include "dlr_consts.svh"

module dlr_block #(
  parameter logic [31:0] EEPROM_BYTES = 32'h0000_0000
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire dlr_pkg::dlr_od_req_t od_req,
  output dlr_pkg::dlr_od_rsp_t      od_rsp,
  input  wire dlr_pkg::dlr_sense_t  sense,
  input  wire logic                 limit_overrun,
  input  wire logic                 brake_done,
  input  wire logic [15:0]          command_word,
  output logic [15:0]               device_state_word,
  output dlr_pkg::dlr_state_t       drive_state,
  output dlr_pkg::dlr_ramp_t        brake_ramp,
  output logic                      motor_energized,
  output logic                      ballast_on
);
  import dlr_pkg::*;

  logic [15:0] limit_overrun_reaction;
  logic [31:0] hardware_config_word;
  logic [31:0] ballast_settings;
  logic [31:0] ballast_limit_mv;
  logic [31:0] ballast_hyst_mv;
  logic [2:0]  lim_sync;
  logic        lim_level;
  logic        lim_prev;
  logic        overrun_event;
  logic        warning;
  logic        qs_prev;
  logic        qs_armed;
  dlr_state_t  state;
  dlr_state_t  next_state;
  dlr_ramp_t   next_ramp;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_value;
  logic signed [32:0] off_level;

  function automatic logic hit(input logic [15:0] idx, input logic [7:0] sub,
                               input logic [15:0] want_idx, input logic [7:0] want_sub);
    hit = (idx == want_idx) && (sub == want_sub);
  endfunction : hit

  // Overrun comes from a switch pin: three stages, edge counts when stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      lim_sync <= 3'h0;
    else
      lim_sync <= {lim_sync[1:0], limit_overrun};
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      lim_level <= 1'b0;
    else if (lim_sync[1] == lim_sync[2])
      lim_level <= lim_sync[2];
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      lim_prev <= 1'b0;
    else
      lim_prev <= lim_level;
  end
  assign overrun_event = lim_level && !lim_prev;
  // Register writes; unmapped or read-only targets answer with an error
  assign wr_hit = od_req.req && od_req.wr &&
                  (hit(od_req.index, od_req.subindex, `DLR_IDX_LIMIT_REACT, `DLR_SUB_COUNT)
                || hit(od_req.index, od_req.subindex, `DLR_IDX_HW_CFG, `DLR_SUB_1)
                || hit(od_req.index, od_req.subindex, `DLR_IDX_BALLAST, `DLR_SUB_1)
                || hit(od_req.index, od_req.subindex, `DLR_IDX_BALLAST, `DLR_SUB_2)
                || hit(od_req.index, od_req.subindex, `DLR_IDX_BALLAST, `DLR_SUB_3));
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      limit_overrun_reaction <= `DLR_RST_REACT;
    else if (od_req.req && od_req.wr &&
             hit(od_req.index, od_req.subindex, `DLR_IDX_LIMIT_REACT, `DLR_SUB_COUNT))
      limit_overrun_reaction <= od_req.wdata[15:0];
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      hardware_config_word <= `DLR_RST_HW_CFG;
    else if (od_req.req && od_req.wr &&
             hit(od_req.index, od_req.subindex, `DLR_IDX_HW_CFG, `DLR_SUB_1))
      hardware_config_word <= od_req.wdata;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ballast_settings <= `DLR_RST_BAL_SET;
      ballast_limit_mv <= `DLR_RST_BAL_LIMIT;
      ballast_hyst_mv  <= `DLR_RST_BAL_HYST;
    end
    else if (od_req.req && od_req.wr && od_req.index == `DLR_IDX_BALLAST)
    begin
      if (od_req.subindex == `DLR_SUB_1)
        ballast_settings <= od_req.wdata;
      if (od_req.subindex == `DLR_SUB_2)
        ballast_limit_mv <= od_req.wdata;
      if (od_req.subindex == `DLR_SUB_3)
        ballast_hyst_mv <= od_req.wdata;
    end
  end
  // Read decode
  always_comb
  begin
    rd_hit   = 1'b1;
    rd_value = 32'h0000_0000;
    case (od_req.index)
      `DLR_IDX_LIMIT_REACT:
        if (od_req.subindex == `DLR_SUB_COUNT)
          rd_value = {{16{limit_overrun_reaction[15]}}, limit_overrun_reaction};
        else
          rd_hit = 1'b0;
      `DLR_IDX_HW_INFO:
        case (od_req.subindex)
          `DLR_SUB_COUNT: rd_value = `DLR_CNT_ONE;
          `DLR_SUB_1:     rd_value = EEPROM_BYTES;
          default:        rd_hit = 1'b0;
        endcase
      `DLR_IDX_HW_CFG:
        case (od_req.subindex)
          `DLR_SUB_COUNT: rd_value = `DLR_CNT_ONE;
          `DLR_SUB_1:     rd_value = hardware_config_word;
          default:        rd_hit = 1'b0;
        endcase
      `DLR_IDX_OP_COND:
        case (od_req.subindex)
          `DLR_SUB_COUNT: rd_value = `DLR_CNT_OP_COND;
          `DLR_SUB_1:     rd_value = sense.supply_mv;
          `DLR_SUB_2:     rd_value = sense.logic_mv;
          `DLR_SUB_3:     rd_value = sense.board_temp;
          `DLR_SUB_4, `DLR_SUB_5: rd_value = 32'h0000_0000;
          default:        rd_hit = 1'b0;
        endcase
      `DLR_IDX_BALLAST:
        case (od_req.subindex)
          `DLR_SUB_COUNT: rd_value = `DLR_CNT_BALLAST;
          `DLR_SUB_1:     rd_value = ballast_settings;
          `DLR_SUB_2:     rd_value = ballast_limit_mv;
          `DLR_SUB_3:     rd_value = ballast_hyst_mv;
          default:        rd_hit = 1'b0;
        endcase
      default:
        rd_hit = 1'b0;
    endcase
  end
  // Answer one cycle after the request; read-only entries refuse writes
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      od_rsp <= '0;
    else
    begin
      od_rsp.ack   <= od_req.req;
      od_rsp.err   <= od_req.req && (od_req.wr ? !wr_hit : !rd_hit);
      od_rsp.rdata <= (od_req.req && !od_req.wr && rd_hit) ? rd_value : 32'h0000_0000;
    end
  end
  // Quick-stop bit is only observed, never written here; re-arm needs a 0 then 1
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      qs_prev <= 1'b1; // Idle level of the bit, so no false rising edge after reset
    else
      qs_prev <= command_word[`DLR_CMD_QS_BIT];
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      qs_armed <= 1'b0;
    else if (state != DLR_QUICK_STOP_ACTIVE)
      qs_armed <= 1'b0;
    else if (!command_word[`DLR_CMD_QS_BIT])
      qs_armed <= 1'b1;
  end

  always_comb
  begin
    next_state = state;
    next_ramp  = DLR_RAMP_NONE;
    case (state)
      DLR_OP_ENABLED:
        if (overrun_event)
        begin
          case (limit_overrun_reaction)
            `DLR_REACT_SLOW_DIS, `DLR_REACT_QUICK_DIS:
              next_state = DLR_BRAKE_DIS;
            `DLR_REACT_SLOW_QS, `DLR_REACT_QUICK_QS:
              next_state = DLR_BRAKE_QS;
            default:
              next_state = DLR_OP_ENABLED;
          endcase
          case (limit_overrun_reaction)
            `DLR_REACT_SLOW_DIS, `DLR_REACT_SLOW_QS:
              next_ramp = DLR_RAMP_SLOW;
            `DLR_REACT_QUICK_DIS, `DLR_REACT_QUICK_QS:
              next_ramp = DLR_RAMP_QUICK;
            default:
              next_ramp = DLR_RAMP_NONE;
          endcase
        end
      DLR_BRAKE_DIS:
        if (brake_done)
          next_state = DLR_SWITCH_ON_DISABLED;
      DLR_BRAKE_QS:
        if (brake_done)
          next_state = DLR_QUICK_STOP_ACTIVE;
      DLR_QUICK_STOP_ACTIVE:
        if (qs_armed && command_word[`DLR_CMD_QS_BIT] && !qs_prev)
          next_state = DLR_OP_ENABLED;
      DLR_SWITCH_ON_DISABLED:
        next_state = DLR_SWITCH_ON_DISABLED;
      default:
        next_state = DLR_OP_ENABLED;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= DLR_OP_ENABLED;
    else
      state <= next_state;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      brake_ramp <= DLR_RAMP_NONE;
    else if (state == DLR_OP_ENABLED)
      brake_ramp <= next_ramp;
    else if ((state == DLR_BRAKE_DIS || state == DLR_BRAKE_QS) && brake_done)
      brake_ramp <= DLR_RAMP_NONE;
  end
  // Warning outlives a no-reaction overrun, so the host still sees it while homing
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      warning <= 1'b0;
    else if (overrun_event)
      warning <= 1'b1;
    else if (state == DLR_QUICK_STOP_ACTIVE && next_state == DLR_OP_ENABLED)
      warning <= 1'b0;
  end
  assign drive_state     = state;
  assign motor_energized = (state != DLR_SWITCH_ON_DISABLED);
  always_comb
  begin
    device_state_word = 16'h0000;
    device_state_word[`DLR_STAT_WARN_BIT] = warning;
  end
  // Ballast comparator with hysteresis; supply reading is treated as signed
  assign off_level = $signed({1'b0, ballast_limit_mv}) - $signed({1'b0, ballast_hyst_mv});
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ballast_on <= 1'b0;
    else if (!ballast_settings[`DLR_BAL_EN_BIT])
      ballast_on <= 1'b0;
    else if ($signed({sense.supply_mv[31], sense.supply_mv}) >
             $signed({1'b0, ballast_limit_mv}))
      ballast_on <= 1'b1;
    else if ($signed({sense.supply_mv[31], sense.supply_mv}) < off_level)
      ballast_on <= 1'b0;
  end
endmodule : dlr_block

/* File: tb/dlr_block_checker.sv */
// Assertions on the dictionary access and limit reaction ports
`timescale 1ns/1ps
module dlr_block_checker
  import dlr_pkg::*;
#(
  parameter logic [31:0] EEPROM_BYTES = 32'h0000_0000
) (
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  input wire dlr_pkg::dlr_od_req_t od_req,
  input wire dlr_pkg::dlr_od_rsp_t od_rsp,
  input wire dlr_pkg::dlr_sense_t  sense,
  input wire logic                 limit_overrun,
  input wire logic                 brake_done,
  input wire logic [15:0]          command_word,
  input wire logic [15:0]          device_state_word,
  input wire dlr_pkg::dlr_state_t  drive_state,
  input wire dlr_pkg::dlr_ramp_t   brake_ramp,
  input wire logic                 motor_energized,
  input wire logic                 ballast_on
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic rd;
  assign rd = od_req.req && !od_req.wr;

  a_ro_write_err: assert property (od_req.req && od_req.wr && od_req.index == 16'h4014
    |=> od_rsp.ack && od_rsp.err) else $error("write to readings not refused");
  a_count_five: assert property (rd && od_req.index == 16'h4014 && od_req.subindex == 8'h00
    |=> od_rsp.rdata == 32'h0000_0005) else $error("reading count wrong");
  a_eeprom_size: assert property (rd && od_req.index == 16'h4012 && od_req.subindex == 8'h01
    |=> od_rsp.rdata == EEPROM_BYTES && !od_rsp.err) else $error("eeprom size wrong");
  a_supply_read: assert property (rd && od_req.index == 16'h4014 && od_req.subindex == 8'h01
    |=> od_rsp.rdata == $past(sense.supply_mv)) else $error("supply reading wrong");
  a_warn_rise: assert property ($rose(limit_overrun) |-> ##[3:5] device_state_word[7])
    else $error("warning not raised after overrun");
  a_energy_state: assert property (motor_energized == (drive_state != DLR_SWITCH_ON_DISABLED))
    else $error("motor energy does not match state");
  a_dis_final: assert property (drive_state == DLR_SWITCH_ON_DISABLED |=>
    drive_state == DLR_SWITCH_ON_DISABLED) else $error("left switch-on-disabled");
  a_qs_return: assert property (drive_state == DLR_QUICK_STOP_ACTIVE && !command_word[2]
    ##1 command_word[2] |-> ##[1:2] drive_state == DLR_OP_ENABLED) else $error("no return");
  a_ramp_brake: assert property (brake_ramp != DLR_RAMP_NONE |->
    drive_state inside {DLR_BRAKE_DIS, DLR_BRAKE_QS}) else $error("ramp outside braking");

  c_refused: cover property (od_rsp.ack && od_rsp.err);
  c_qs_active: cover property (drive_state == DLR_QUICK_STOP_ACTIVE);
  c_ballast: cover property ($rose(ballast_on));
endmodule : dlr_block_checker

/* File: tb/dlr_host.sv */
// Host model issuing dictionary accesses and quick-stop command changes
`timescale 1ns/1ps
module dlr_host
  import dlr_pkg::*;
(
  input  wire logic            ref_clk,
  output dlr_pkg::dlr_od_req_t od_req,
  output logic [15:0]          command_word
);
  initial
  begin
    od_req = '0;
    command_word = 16'h0004;
  end

  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] data);
    @(posedge ref_clk);
    od_req <= '{req: 1'b1, wr: wr, index: idx, subindex: sub, wdata: data};
  endtask : access

  // Released fields are inverted so a stale value never looks valid
  task automatic release_bus();
    @(posedge ref_clk);
    od_req <= {1'b0, ~od_req[56:0]};
  endtask : release_bus

  task automatic quick_stop_cycle();
    @(posedge ref_clk);
    command_word[2] <= 1'b0;
    repeat (2) @(posedge ref_clk);
    command_word[2] <= 1'b1;
  endtask : quick_stop_cycle
endmodule : dlr_host

/* File: tb/drive_limit_reaction_and_hw_info_tb_top.sv */
// Self-checking bench for the limit reaction and hardware info bank
`timescale 1ns/1ps
module drive_limit_reaction_and_hw_info_tb_top;
  import dlr_pkg::*;
  localparam logic [31:0] EEPROM_BYTES = 32'h0000_2000;
  localparam logic [15:0] CODE [6] = '{16'hffff, 16'h0003, 16'h0001, 16'h0002, 16'h0005, 16'h0006};
  localparam dlr_state_t BRK [6] = '{DLR_OP_ENABLED, DLR_OP_ENABLED, DLR_BRAKE_DIS,
    DLR_BRAKE_DIS, DLR_BRAKE_QS, DLR_BRAKE_QS};
  localparam dlr_ramp_t RMP [6] = '{DLR_RAMP_NONE, DLR_RAMP_NONE, DLR_RAMP_SLOW,
    DLR_RAMP_QUICK, DLR_RAMP_SLOW, DLR_RAMP_QUICK};
  localparam dlr_state_t FIN [6] = '{DLR_OP_ENABLED, DLR_OP_ENABLED, DLR_SWITCH_ON_DISABLED,
    DLR_SWITCH_ON_DISABLED, DLR_QUICK_STOP_ACTIVE, DLR_QUICK_STOP_ACTIVE};
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        limit_overrun = 1'b0;
  logic        brake_done = 1'b0;
  dlr_sense_t  sense = '0;
  dlr_od_req_t od_req;
  dlr_od_rsp_t od_rsp;
  logic [15:0] command_word;
  logic [15:0] device_state_word;
  dlr_state_t  drive_state;
  dlr_ramp_t   brake_ramp;
  logic        motor_energized;
  logic        ballast_on;
  logic [32:0] exp_q[$];
  logic [31:0] v;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;

  always #2.5 ref_clk = ~ref_clk;

  dlr_host i_host (.ref_clk, .od_req, .command_word);
  dlr_block #(.EEPROM_BYTES(EEPROM_BYTES)) i_dut (.ref_clk, .rst_n, .od_req, .od_rsp, .sense,
    .limit_overrun, .brake_done, .command_word, .device_state_word, .drive_state,
    .brake_ramp, .motor_energized, .ballast_on);

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [32:0] exp);
    exp_q.push_back(exp);
    i_host.access(1'b0, idx, sub, 32'h0);
  endtask : rd

  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
                    input logic e);
    exp_q.push_back({e, 32'h0});
    i_host.access(1'b1, idx, sub, d);
  endtask : wr

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_cyc

  task automatic flush(input string name);
    i_host.release_bus();
    repeat (3) @(posedge ref_clk);
    $display("test %s done", name);
  endtask : flush

  task automatic do_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic supply_step(input logic [31:0] mv, input logic exp);
    @(posedge ref_clk);
    sense.supply_mv <= mv;
    wait_cyc(6);
    check(ballast_on, exp);
  endtask : supply_step

  // Every answer is matched in order against the oldest expectation
  always @(posedge ref_clk)
    if (rst_n === 1'b1 && od_rsp.ack === 1'b1)
      check({od_rsp.err, od_rsp.rdata}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      finish_test();
    end
  end

  initial
  begin
    v = $urandom(32'hdea2);
    @(posedge ref_clk);
    sense <= '{$urandom, $urandom, $urandom};
    repeat (7) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(16'h3701, 8'h00, 33'h0_ffff_ffff);
    rd(16'h4012, 8'h00, 33'h1);
    rd(16'h4012, 8'h01, {1'b0, EEPROM_BYTES});
    rd(16'h4013, 8'h01, 33'h0);
    rd(16'h4014, 8'h00, 33'h5);
    rd(16'h4014, 8'h01, {1'b0, sense.supply_mv});
    rd(16'h4014, 8'h02, {1'b0, sense.logic_mv});
    rd(16'h4014, 8'h03, {1'b0, sense.board_temp});
    rd(16'h4014, 8'h04, 33'h0);
    rd(16'h4014, 8'h05, 33'h0);
    rd(16'h4021, 8'h01, 33'h1);
    rd(16'h4021, 8'h02, 33'h6860);
    rd(16'h4021, 8'h03, 33'h1f4);
    v = $urandom;
    wr(16'h4014, 8'h01, v, 1'b1);
    wr(16'h4012, 8'h01, v, 1'b1);
    rd(16'h5a5a, 8'h00, 33'h1_0000_0000);
    wr(16'h4013, 8'h01, v, 1'b0);
    rd(16'h4013, 8'h01, {1'b0, v});
    wr(16'h3701, 8'h00, {v[31:16], 16'h8000}, 1'b0);
    rd(16'h3701, 8'h00, 33'h0_ffff_8000);
    flush("registers");
    foreach (CODE[i])
    begin
      do_reset();
      wr(16'h3701, 8'h00, {16'h0, CODE[i]}, 1'b0);
      i_host.release_bus();
      limit_overrun <= 1'b1;
      wait_cyc(6);
      check(device_state_word[7], 1'b1);
      check({drive_state, brake_ramp}, {BRK[i], RMP[i]});
      @(posedge ref_clk);
      limit_overrun <= 1'b0;
      brake_done <= 1'b1;
      @(posedge ref_clk);
      brake_done <= 1'b0;
      wait_cyc(3);
      check({drive_state, motor_energized}, {FIN[i], FIN[i] != DLR_SWITCH_ON_DISABLED});
      if (FIN[i] == DLR_QUICK_STOP_ACTIVE)
      begin
        check(device_state_word[7], 1'b1);
        i_host.quick_stop_cycle();
        wait_cyc(3);
        check({drive_state, device_state_word[7]}, {DLR_OP_ENABLED, 1'b0});
      end
      $display("test reaction %h done", CODE[i]);
    end
    do_reset();
    supply_step(32'h0000_7000, 1'b1);
    supply_step(32'h0000_666d, 1'b1);
    supply_step(32'h0000_666b, 1'b0);
    supply_step(32'h0000_7000, 1'b1);
    wr(16'h4021, 8'h01, 32'h0, 1'b0);
    i_host.release_bus();
    supply_step(32'h0000_7000, 1'b0);
    wr(16'h4021, 8'h02, 32'h0000_8000, 1'b0);
    wr(16'h4021, 8'h01, 32'h1, 1'b0);
    i_host.release_bus();
    supply_step(32'h0000_7000, 1'b0);
    supply_step(32'h0000_8001, 1'b1);
    flush("ballast");
    finish_test();
  end
endmodule : drive_limit_reaction_and_hw_info_tb_top

bind dlr_block dlr_block_checker #(.EEPROM_BYTES(EEPROM_BYTES)) i_chk (.ref_clk, .rst_n,
  .od_req, .od_rsp, .sense, .limit_overrun, .brake_done, .command_word, .device_state_word,
  .drive_state, .brake_ramp, .motor_energized, .ballast_on);
